// ==== design/bfs_pkg.sv ====
package bfs_pkg;

  // Clock and protection times
  localparam int CLK_PERIOD_NS = 8;
  localparam int HOLD_MS = 25;
  localparam int ZERO_MS = 30;
  localparam int SHORT_MS = 3;
  localparam int STEP_MS = 1;
  localparam int OPEN_MS = 10;
  localparam int OVERCUR_MS = 2;
  localparam int NS_PER_MS = 1000000;
  localparam int HOLD_CYC = HOLD_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int ZERO_CYC = ZERO_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int SHORT_CYC = SHORT_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int STEP_CYC = STEP_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int OPEN_CYC = OPEN_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int OVERCUR_CYC = OVERCUR_MS * NS_PER_MS / CLK_PERIOD_NS;

  // Register map and field positions
  localparam logic [7:0] ADDR_CTRL = 8'h02;
  localparam logic [7:0] ADDR_FAULT = 8'h10;
  localparam logic [7:0] CTRL_RST = 8'hD0;
  localparam int CTL_SHORT_EN = 4;
  localparam int CTL_DIM_LO = 6;
  localparam int FLT_OVERTEMP = 7;
  localparam int FLT_STRING = 6;
  localparam int FLT_OVERCUR = 4;
  localparam int FLT_CHAN0 = 1;
  localparam logic [2:0] SS_LAST = 3'h7;

  typedef logic [21:0] bfs_cnt_t;

  typedef enum logic [2:0] {
    S_OFF = 3'h0,
    S_PRE = 3'h1,
    S_SOFT = 3'h2,
    S_RUN = 3'h3,
    S_HOLD = 3'h4,
    S_IDLE = 3'h5,
    S_ZERO = 3'h6,
    S_HOT = 3'h7
  } bfs_state_t;

  // Comparator and pin levels from the analog side
  typedef struct packed {
    logic enable;
    logic supplyOkMain;
    logic supplyOkIo;
    logic overTemp;
    logic swAtLimit;
    logic boostOutputAboveStart;
    logic peakReached;
    logic [1:0] ledChannelGood;
    logic [1:0] ledChannelHigh;
    logic [1:0] ledChannelPinOv;
  } bfs_sense_t;

  typedef struct packed {
    bfs_state_t state;
    bfs_cnt_t tmr;
    logic [2:0] ssStep;
    bfs_cnt_t overcurTmr;
    bfs_cnt_t [1:0] openTmr;
    bfs_cnt_t [1:0] shortTmr;
    logic [1:0] chanOff;
    logic [1:0] chanBad;
    logic hotLatch;
    logic seenLow;
    logic stable;
    logic [7:0] ctrl;
    logic [7:0] fault;
    logic [7:0] rdData;
    bfs_sense_t sync1;
    bfs_sense_t sync2;
  } bfs_regs_t;

  localparam bfs_regs_t REGS_RST = '{state: S_OFF, ctrl: CTRL_RST,
                                     default: '0};

endpackage

// ==== design/bfs_sequencer.sv ====
// Overview of operation
// - Zero brightness keeps boost on 25ms, then off
// - Zero-current entered 30ms after zero brightness (5ms off), wakes for commands
// - Digital inputs stay active while enable high
// - Valid non-zero command wakes and relights strings
// - Switch at limit ends cycle, resumes after
// - Timed overcurrent sets fault bit 4, not soft-start
// - Good channel marked; low channel timed, then off
// - Open sets bit 6, clears that channel status
// - Headroom above short level 3ms disables normal channel
// - Short guard off enables pin overvoltage clamp
// - Supply lockout stops boost and current sinks
// - Lockout keeps registers; only deep reset clears
// - Over-temperature shuts down, bit 7, needs cycling
// - Start needs supplies, enable and non-zero brightness
// - Low-current boost until output above start level
// - Soft-start limit steps 125mA to 1A in 7ms
// - Soft-start ends early when peak is enough
// - Lockout, enable low or zero brightness powers down
// - Open, short and overcurrent faults judged only in stable operation
// - Control bits 7:6 select dimming, default 11
`timescale 1ns/100ps

module bfs_sequencer #(
  parameter int HOLD_CYC = bfs_pkg::HOLD_CYC,
  parameter int ZERO_CYC = bfs_pkg::ZERO_CYC,
  parameter int SHORT_CYC = bfs_pkg::SHORT_CYC,
  parameter int STEP_CYC = bfs_pkg::STEP_CYC,
  parameter int OPEN_CYC = bfs_pkg::OPEN_CYC,
  parameter int OVERCUR_CYC = bfs_pkg::OVERCUR_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire bfs_pkg::bfs_sense_t senseIn,
  input wire logic brightNonZero,
  input wire logic cmdValid,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic boostEn,
  output logic lowPowerStart,
  output logic switchOff,
  output logic [2:0] curLimitStep,
  output logic [1:0] sinkEn,
  output logic headroomCap,
  output logic outputClamp,
  output logic zeroCurrent,
  output logic wakePulse,
  output logic ioActive,
  output logic shortGuardEn,
  output logic [1:0] dimMode
);

  bfs_pkg::bfs_regs_t st_ff;
  bfs_pkg::bfs_regs_t nxt_st;
  bfs_pkg::bfs_sense_t sn;
  logic supOk;
  logic powerOk;
  logic running;
  logic [1:0] openCond;
  logic [1:0] shortCond;
  logic overcurCond;

  // Counter step with saturation, restarts when run drops
  function automatic bfs_pkg::bfs_cnt_t tick(bfs_pkg::bfs_cnt_t c,
                                             logic run);
    if (!run) begin
      return '0;
    end
    return (c == 22'h3FFFFF) ? c : c + 22'h000001;
  endfunction

  // Synchronised levels and start conditions
  assign sn = st_ff.sync2;
  assign supOk = sn.supplyOkMain & sn.supplyOkIo;
  assign powerOk = supOk & sn.enable & ~st_ff.hotLatch;
  assign running = (st_ff.state == bfs_pkg::S_RUN) & st_ff.stable;

  // Fault conditions, judged only once stable
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      openCond[i] = running & ~st_ff.chanOff[i]
                    & ~sn.ledChannelGood[i]
                    & sn.ledChannelGood[1-i];
      shortCond[i] = running & ~st_ff.chanOff[i]
                     & st_ff.ctrl[bfs_pkg::CTL_SHORT_EN]
                     & sn.ledChannelHigh[i];
    end
    overcurCond = running & sn.swAtLimit;
  end

  // Next-state logic of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = senseIn;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.tmr = tick(st_ff.tmr, 1'b1);

    // Register port; contents survive lockout
    if (regWrEn && regAddr == bfs_pkg::ADDR_CTRL) begin
      nxt_st.ctrl = regWrData;
    end
    unique case (regAddr)
      bfs_pkg::ADDR_CTRL: nxt_st.rdData = st_ff.ctrl;
      bfs_pkg::ADDR_FAULT: nxt_st.rdData = st_ff.fault;
      default: nxt_st.rdData = 8'h00;
    endcase

    // Main sequence
    unique case (st_ff.state)
      bfs_pkg::S_OFF: begin
        if (powerOk && brightNonZero) begin
          nxt_st.state = bfs_pkg::S_PRE;
          nxt_st.chanOff = 2'h0;
          nxt_st.chanBad = 2'h0;
        end
      end
      bfs_pkg::S_PRE: begin
        nxt_st.ssStep = 3'h0;
        if (sn.boostOutputAboveStart) begin
          nxt_st.state = bfs_pkg::S_SOFT;
          nxt_st.tmr = '0;
        end
      end
      bfs_pkg::S_SOFT: begin
        if (sn.peakReached) begin
          nxt_st.state = bfs_pkg::S_RUN;
        end else if (st_ff.tmr == bfs_pkg::bfs_cnt_t'(STEP_CYC - 1)) begin
          nxt_st.tmr = '0;
          if (st_ff.ssStep == bfs_pkg::SS_LAST) begin
            nxt_st.state = bfs_pkg::S_RUN;
          end else begin
            nxt_st.ssStep = st_ff.ssStep + 3'h1;
          end
        end
      end
      bfs_pkg::S_RUN: begin
        if (|(sn.ledChannelGood & ~st_ff.chanOff)) begin
          nxt_st.stable = 1'b1;
        end
      end
      bfs_pkg::S_HOLD: begin
        if (brightNonZero) begin
          nxt_st.state = bfs_pkg::S_RUN;
        end else if (st_ff.tmr == bfs_pkg::bfs_cnt_t'(HOLD_CYC - 1)) begin
          nxt_st.state = bfs_pkg::S_IDLE;
        end
      end
      bfs_pkg::S_IDLE: begin
        if (brightNonZero) begin
          nxt_st.state = bfs_pkg::S_PRE;
        end else if (st_ff.tmr == bfs_pkg::bfs_cnt_t'(ZERO_CYC - 1)) begin
          nxt_st.state = bfs_pkg::S_ZERO;
        end
      end
      bfs_pkg::S_ZERO: begin
        if (cmdValid && brightNonZero) begin
          nxt_st.state = bfs_pkg::S_PRE;
        end
      end
      bfs_pkg::S_HOT: begin
        if (!sn.enable || !sn.supplyOkMain) begin
          nxt_st.seenLow = 1'b1;
        end
        if (!sn.overTemp && st_ff.seenLow && supOk && sn.enable) begin
          nxt_st.state = bfs_pkg::S_OFF;
          nxt_st.hotLatch = 1'b0;
        end
      end
    endcase

    // Zero brightness from any lit state starts the hold
    if (!brightNonZero && (st_ff.state == bfs_pkg::S_PRE ||
        st_ff.state == bfs_pkg::S_SOFT ||
        st_ff.state == bfs_pkg::S_RUN)) begin
      nxt_st.state = bfs_pkg::S_HOLD;
      nxt_st.tmr = '0;
    end

    // Lockout or enable low powers down
    if ((!supOk || !sn.enable) && st_ff.state != bfs_pkg::S_HOT) begin
      nxt_st.state = bfs_pkg::S_OFF;
    end

    // Over-temperature shutdown, latched
    if (sn.overTemp && st_ff.state != bfs_pkg::S_HOT) begin
      nxt_st.state = bfs_pkg::S_HOT;
      nxt_st.hotLatch = 1'b1;
      nxt_st.seenLow = 1'b0;
      nxt_st.fault[bfs_pkg::FLT_OVERTEMP] = 1'b1;
    end

    if (nxt_st.state != bfs_pkg::S_RUN) begin
      nxt_st.stable = 1'b0;
    end

    // Overcurrent report after its timeout
    nxt_st.overcurTmr = tick(st_ff.overcurTmr, overcurCond);
    if (overcurCond &&
        st_ff.overcurTmr == bfs_pkg::bfs_cnt_t'(OVERCUR_CYC - 1)) begin
      nxt_st.fault[bfs_pkg::FLT_OVERCUR] = 1'b1;
    end

    // Open and short string timeouts per channel
    for (int i = 0; i < 2; i++) begin
      nxt_st.openTmr[i] = tick(st_ff.openTmr[i], openCond[i]);
      nxt_st.shortTmr[i] = tick(st_ff.shortTmr[i], shortCond[i]);
      if (openCond[i] &&
          st_ff.openTmr[i] == bfs_pkg::bfs_cnt_t'(OPEN_CYC - 1)) begin
        nxt_st.chanOff[i] = 1'b1;
        nxt_st.chanBad[i] = 1'b1;
        nxt_st.fault[bfs_pkg::FLT_STRING] = 1'b1;
      end
      if (shortCond[i] &&
          st_ff.shortTmr[i] == bfs_pkg::bfs_cnt_t'(SHORT_CYC - 1)) begin
        nxt_st.chanOff[1-i] = 1'b1;
        nxt_st.chanBad[i] = 1'b1;
        nxt_st.fault[bfs_pkg::FLT_STRING] = 1'b1;
      end
    end

    // Channel status bits follow good and not faulted
    for (int i = 0; i < 2; i++) begin
      nxt_st.fault[bfs_pkg::FLT_CHAN0 + i] = sn.ledChannelGood[i]
        & ~nxt_st.chanOff[i] & ~nxt_st.chanBad[i];
    end
  end

  // State register; only the deep supply reset clears it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= bfs_pkg::REGS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Drive to the boost, sinks and host side
  always_comb begin
    boostEn = st_ff.state == bfs_pkg::S_PRE ||
              st_ff.state == bfs_pkg::S_SOFT ||
              st_ff.state == bfs_pkg::S_RUN ||
              st_ff.state == bfs_pkg::S_HOLD;
    lowPowerStart = st_ff.state == bfs_pkg::S_PRE;
    for (int i = 0; i < 2; i++) begin
      sinkEn[i] = (st_ff.state == bfs_pkg::S_SOFT ||
                   st_ff.state == bfs_pkg::S_RUN ||
                   st_ff.state == bfs_pkg::S_HOLD) & ~st_ff.chanOff[i];
    end
    curLimitStep = (st_ff.state == bfs_pkg::S_PRE ||
                    st_ff.state == bfs_pkg::S_SOFT) ?
                   st_ff.ssStep : bfs_pkg::SS_LAST;
  end

  assign switchOff = ~boostEn | sn.swAtLimit;
  assign headroomCap = |{st_ff.openTmr[0] != '0,
                         st_ff.openTmr[1] != '0};
  assign shortGuardEn = st_ff.ctrl[bfs_pkg::CTL_SHORT_EN];
  assign outputClamp = (~shortGuardEn | headroomCap) &
                       |(sn.ledChannelPinOv & ~st_ff.chanOff);
  assign zeroCurrent = st_ff.state == bfs_pkg::S_ZERO;
  assign wakePulse = zeroCurrent & cmdValid;
  assign ioActive = sn.enable;
  assign dimMode = st_ff.ctrl[bfs_pkg::CTL_DIM_LO +: 2];
  assign regRdData = st_ff.rdData;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wake;
    zeroCurrent && cmdValid && brightNonZero;
  endsequence

  sequence s_hot;
    sn.overTemp && st_ff.state != bfs_pkg::S_HOT;
  endsequence

  property p_hold;
    $rose(st_ff.state == bfs_pkg::S_IDLE) |->
      $past(st_ff.tmr) == bfs_pkg::bfs_cnt_t'(HOLD_CYC - 1);
  endproperty
  a_hold: assert property (p_hold)
    else $error("boost hold ended at wrong count");

  property p_zero;
    $rose(zeroCurrent) |->
      $past(st_ff.tmr) == bfs_pkg::bfs_cnt_t'(ZERO_CYC - 1);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero-current entered at wrong count");

  property p_wake;
    s_wake |=> boostEn && lowPowerStart;
  endproperty
  a_wake: assert property (p_wake)
    else $error("valid command did not wake");

  // Limit cuts the cycle but leaves the regulator running
  property p_limit;
    sn.swAtLimit && running && powerOk && brightNonZero && !sn.overTemp
      |-> switchOff ##1 boostEn;
  endproperty
  a_limit: assert property (p_limit)
    else $error("switch not held off at limit");

  property p_overcur;
    $rose(st_ff.fault[bfs_pkg::FLT_OVERCUR]) |->
      $past(st_ff.state) == bfs_pkg::S_RUN &&
      $past(st_ff.overcurTmr) ==
        bfs_pkg::bfs_cnt_t'(OVERCUR_CYC - 1);
  endproperty
  a_overcur: assert property (p_overcur)
    else $error("overcurrent flagged early or in soft-start");

  property p_bad;
    $rose(st_ff.chanBad[0]) |->
      st_ff.fault[bfs_pkg::FLT_STRING] && !st_ff.fault[1];
  endproperty
  a_bad: assert property (p_bad)
    else $error("string fault bits wrong");

  property p_uv;
    !supOk && st_ff.state != bfs_pkg::S_HOT |=>
      !boostEn && sinkEn == 2'h0;
  endproperty
  a_uv: assert property (p_uv)
    else $error("lockout left boost or sinks on");

  property p_hot;
    s_hot |=> st_ff.state == bfs_pkg::S_HOT && !boostEn
      && st_ff.fault[bfs_pkg::FLT_OVERTEMP];
  endproperty
  a_hot: assert property (p_hot)
    else $error("over-temperature not shut down");

  property p_start;
    $rose(lowPowerStart) |-> $past(brightNonZero) &&
      ($past(powerOk) || $past(zeroCurrent) ||
       $past(st_ff.state) == bfs_pkg::S_IDLE);
  endproperty
  a_start: assert property (p_start)
    else $error("started without conditions");

endmodule // bfs_sequencer

// ==== tb/bfs_host_model.sv ====
`timescale 1ns/100ps

// Host side: enable level and brightness commands
module bfs_host_model (
  input wire logic mclk,
  input wire logic ioUp,
  output logic enable,
  output logic brightNonZero,
  output logic cmdValid
);
  initial begin
    enable = 1'h0;
    brightNonZero = 1'h0;
    cmdValid = 1'h0;
  end

  // Enable changes only after a falling edge
  task automatic setEn(input logic v);
    @(negedge mclk);
    enable = v;
  endtask

  // A command is sent only with the I/O supply up
  task automatic send(input logic v);
    @(negedge mclk);
    if (ioUp) begin
      brightNonZero = v;
      cmdValid = 1'h1;
    end
    @(negedge mclk);
    cmdValid = 1'h0;
  endtask
endmodule // bfs_host_model

// ==== tb/tb.sv ====
`timescale 1ns/100ps

module tb;
  logic mclk, rst_n, brightNonZero, cmdValid, hEn, regWrEn;
  bfs_pkg::bfs_sense_t sn, senseIn;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [2:0] curLimitStep;
  logic [1:0] sinkEn, dimMode;
  logic boostEn, lowPowerStart, switchOff, headroomCap, outputClamp;
  logic zeroCurrent, wakePulse, ioActive, shortGuardEn;
  int errTotal, nCompared;

  bfs_sequencer #(.HOLD_CYC(20), .ZERO_CYC(30), .SHORT_CYC(8),
    .STEP_CYC(4), .OPEN_CYC(10), .OVERCUR_CYC(6)) dut (
    .mclk, .rst_n, .senseIn, .brightNonZero, .cmdValid, .regWrEn,
    .regAddr, .regWrData, .regRdData, .boostEn, .lowPowerStart,
    .switchOff, .curLimitStep, .sinkEn, .headroomCap, .outputClamp,
    .zeroCurrent, .wakePulse, .ioActive, .shortGuardEn, .dimMode);

  bfs_host_model host (.mclk, .ioUp(sn.supplyOkIo), .enable(hEn),
    .brightNonZero, .cmdValid);

  // Enable comes from the host, the rest from the bench
  always_comb begin
    senseIn = sn;
    senseIn.enable = hEn;
  end

  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    nCompared++;
    if (s !== e) begin
      errTotal++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    cyc(2);
    chk(regRdData, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'h1;
    cyc(1);
    regWrEn = 1'h0;
    cyc(1);
  endtask

  task automatic rstDut();
    rst_n = 1'h0;
    sn = '0;
    cyc(6);
    rst_n = 1'h1;
    cyc(1);
  endtask

  // Power up into regulation, with or without early peak
  task automatic startUp(input logic pk);
    sn.supplyOkMain = 1'h1;
    sn.supplyOkIo = 1'h1;
    sn.ledChannelGood = 2'h3;
    host.setEn(1'h1);
    host.send(1'h1);
    cyc(5);
    chk(lowPowerStart, 8'h1);
    chk(sinkEn, 8'h0);
    sn.peakReached = pk;
    sn.boostOutputAboveStart = 1'h1;
    cyc(5);
    if (pk) begin
      cyc(4);
      chk(curLimitStep, 8'h7);
    end else begin
      for (int i = 0; i < 8; i++) begin
        chk(curLimitStep, i[7:0]);
        cyc(4);
      end
    end
    chk(sinkEn, 8'h3);
    chk(lowPowerStart, 8'h0);
  endtask

  task automatic tReset();
    chk(dimMode, 8'h3);
    chk(shortGuardEn, 8'h1);
    rd(8'h02, bfs_pkg::CTRL_RST);
    sn.supplyOkMain = 1'h1;
    sn.supplyOkIo = 1'h1;
    host.setEn(1'h1);
    host.send(1'h0);
    cyc(5);
    chk(boostEn, 8'h0);
    $display("test reset done");
  endtask

  task automatic tOcp();
    startUp(1'h0);
    sn.swAtLimit = 1'h1;
    cyc(3);
    chk(switchOff, 8'h1);
    chk(boostEn, 8'h1);
    sn.swAtLimit = 1'h0;
    cyc(3);
    chk(switchOff, 8'h0);
    rd(8'h10, 8'h06);
    sn.swAtLimit = 1'h1;
    cyc(12);
    sn.swAtLimit = 1'h0;
    rd(8'h10, 8'h16);
    $display("test overcurrent done");
  endtask

  task automatic tHold();
    host.send(1'h0);
    cyc(15);
    chk(boostEn, 8'h1);
    cyc(10);
    chk(boostEn, 8'h0);
    chk(zeroCurrent, 8'h0);
    cyc(10);
    chk(zeroCurrent, 8'h1);
    chk(ioActive, 8'h1);
    fork
      host.send(1'h1);
      begin
        cyc(1);
        #1 chk(wakePulse, 8'h1);
      end
    join
    cyc(5);
    chk(zeroCurrent, 8'h0);
    chk(boostEn, 8'h1);
    cyc(40);
    $display("test hold done");
  endtask

  task automatic tRegs();
    wr(8'h33, 8'hFF);
    wr(8'h10, 8'hFF);
    rd(8'h33, 8'h00);
    rd(8'h10, 8'h16);
    for (int m = 0; m < 4; m++) begin
      wr(8'h02, {m[1:0], 6'h00});
      cyc(1);
      chk(dimMode, m[7:0]);
    end
    chk(shortGuardEn, 8'h0);
    sn.ledChannelPinOv = 2'h3;
    cyc(5);
    chk(outputClamp, 8'h1);
    sn.ledChannelPinOv = 2'h0;
    $display("test registers done");
  endtask

  task automatic tLock();
    sn.supplyOkIo = 1'h0;
    sn.supplyOkMain = 1'h0;
    // Output collapses with the boost off, so restart waits in PRE
    sn.boostOutputAboveStart = 1'h0;
    cyc(5);
    chk(boostEn, 8'h0);
    chk(sinkEn, 8'h0);
    rd(8'h02, 8'hC0);
    sn.supplyOkMain = 1'h1;
    sn.supplyOkIo = 1'h1;
    cyc(5);
    chk(lowPowerStart, 8'h1);
    sn.overTemp = 1'h1;
    cyc(5);
    chk(boostEn, 8'h0);
    rd(8'h10, 8'h96);
    sn.overTemp = 1'h0;
    cyc(5);
    chk(boostEn, 8'h0);
    host.setEn(1'h0);
    cyc(5);
    host.setEn(1'h1);
    cyc(5);
    chk(lowPowerStart, 8'h1);
    $display("test lockout done");
  endtask

  task automatic tStrings();
    rstDut();
    rd(8'h02, bfs_pkg::CTRL_RST);
    startUp(1'h0);
    sn.ledChannelGood = 2'h2;
    cyc(5);
    chk(headroomCap, 8'h1);
    cyc(12);
    chk(sinkEn, 8'h2);
    rd(8'h10, 8'h44);
    rstDut();
    startUp(1'h0);
    sn.ledChannelHigh = 2'h1;
    cyc(5);
    chk(sinkEn, 8'h3);
    cyc(10);
    chk(sinkEn, 8'h1);
    regAddr = 8'h10;
    cyc(2);
    chk(regRdData, 8'h40);
    $display("test strings done");
  endtask

  task automatic tPeak();
    rstDut();
    startUp(1'h1);
    host.setEn(1'h0);
    cyc(5);
    chk(boostEn, 8'h0);
    chk(sinkEn, 8'h0);
    $display("test peak done");
  endtask

  task automatic end_of_test();
    $display("compared %0d, wrong %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'h0;
    sn = '0;
    regWrEn = 1'h0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    errTotal = 0;
    nCompared = 0;
    cyc(6);
    rst_n = 1'h1;
    cyc(1);
    tReset();
    tOcp();
    tHold();
    tRegs();
    tLock();
    tStrings();
    tPeak();
    end_of_test();
  end
endmodule // tb
